// [dv/pfm_pad_model.sv]
// Far-side circuitry model for a group of pads
`timescale 1ns/1ns
module pfm_pad_model #(parameter int W = 4) (
    input  wire logic         clk_i,
    input  wire logic         ext_on_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] o_i,
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] pad_o
);
    // Undriven pins wander so no level is read by luck
    logic [W-1:0] flt_q = '0;
    always_ff @(posedge clk_i) flt_q <= ~flt_q;
    assign pad_o = (oe_i & o_i) | (~oe_i & (ext_on_i ? ext_i : flt_q));
endmodule // pfm_pad_model

// [dv/pfm_top_sva.sv]
// Port assertions for the pin function multiplexer
`timescale 1ns/1ns
module pfm_top_sva (
    input wire logic                   clk_i,
    input wire logic                   sys_rst_i,
    input wire logic                   jtag_mode_i,
    input wire pfm_pkg::pfm_jtag_drv_t jtag_drv_i,
    input wire pfm_pkg::pfm_jtag_in_t  jtag_in_o,
    input wire pfm_pkg::pfm_timer_in_t timer_in_o,
    input wire logic [3:0]             p1_pad_i,
    input wire logic [3:0]             p1_pad_o,
    input wire logic [3:0]             p1_pad_oe_o,
    input wire logic [4:0]             p2_pad_o,
    input wire logic [4:0]             p2_pad_oe_o,
    input wire logic [4:0]             analog_channel_en_o
);
    import pfm_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_jtag; jtag_mode_i [*5]; endsequence
    sequence s_held; (jtag_mode_i && $stable(p1_pad_i)) [*5]; endsequence
    a_reset_idle: assert property ($past(sys_rst_i) |->
        p1_pad_oe_o == 4'h0 && p2_pad_oe_o == 5'h00 && analog_channel_en_o == 5'h00)
        else $error("pads active after reset");
    a_analog_no_oe: assert property ((analog_channel_en_o & p2_pad_oe_o) == 5'h00)
        else $error("analog pin driven");
    a_analog_low: assert property ((analog_channel_en_o & p2_pad_o) == 5'h00)
        else $error("analog pin data not low");
    a_clock_in_idle: assert property (analog_channel_en_o[1] [*4] |->
        !timer_in_o.timer_a_inverted_clock_in) else $error("clock input not idle");
    a_capture_idle: assert property ((analog_channel_en_o[2] && analog_channel_en_o[3]) [*4]
        |-> !timer_in_o.timer_a_capture_in_0_alt && !timer_in_o.timer_a_capture_in_1_alt)
        else $error("capture input not idle");
    a_jtag_no_oe: assert property (s_jtag |-> p1_pad_oe_o[2:0] == 3'h0)
        else $error("test pin driven");
    a_tdo_follow: assert property (s_jtag |-> p1_pad_oe_o[3] == $past(jtag_drv_i.tdo_oe)
        && p1_pad_o[3] == $past(jtag_drv_i.tdo)) else $error("test output wrong");
    a_tck_follow: assert property (s_held |-> jtag_in_o.tck == p1_pad_i[0]
        && jtag_in_o.tms == p1_pad_i[1] && jtag_in_o.tdi == p1_pad_i[2]) else $error("test in wrong");
endmodule // pfm_top_sva
bind pfm_top pfm_top_sva pfm_top_sva_inst (.*);

// [dv/tb.sv]
// Self-checking testbench for the pin function multiplexer
`timescale 1ns/1ns
module tb;
    import pfm_pkg::*;
    logic          clk_i = 1'b0;
    logic          sys_rst_i = 1'b1;
    logic          power_on_rst_i = 1'b0;
    logic          jtag_mode_i = 1'b0;
    logic          ext_on = 1'b0;
    pfm_bus_req_t  bus_i = '0;
    pfm_periph_t   periph_i = '0;
    pfm_jtag_drv_t jtag_drv_i = '0;
    pfm_jtag_in_t  jtag_in_o;
    pfm_timer_in_t timer_in_o;
    logic [7:0]    rdata_o, r;
    logic [3:0]    p1_pad_i, p1_pad_o, p1_pad_oe_o, p1_ext = 4'h0;
    logic [4:0]    p2_pad_i, p2_pad_o, p2_pad_oe_o, analog_channel_en_o, p2_ext = 5'h00;
    int            n_errors = 0;
    int            tests_run = 0;
    pfm_top pfm_top_inst (.*);
    pfm_pad_model #(.W(4)) pfm_pad_model_inst (.clk_i(clk_i), .ext_on_i(ext_on),
        .oe_i(p1_pad_oe_o), .o_i(p1_pad_o), .ext_i(p1_ext), .pad_o(p1_pad_i));
    pfm_pad_model #(.W(5)) pfm_pad_model_p2_inst (.clk_i(clk_i), .ext_on_i(ext_on),
        .oe_i(p2_pad_oe_o), .o_i(p2_pad_o), .ext_i(p2_ext), .pad_o(p2_pad_i));
    initial forever #25 clk_i = ~clk_i;
    task automatic chk(input string what, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        @(negedge clk_i);
        r = rdata_o;
    endtask
    task automatic cfg(input logic [7:0] d1, s1, d2, s2, ae);
        wr(PFM_ADDR_P1_DIR, d1);
        wr(PFM_ADDR_P1_SEL, s1);
        wr(PFM_ADDR_P2_DIR, d2);
        wr(PFM_ADDR_P2_SEL, s2);
        wr(PFM_ADDR_AE, ae);
    endtask
    task automatic settle();
        repeat (7) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic t_rst();
        for (int a = 0; a < 5; a++)
        begin
            rd(4'(a));
            chk("cfg", 16'(r), 16'h0000);
        end
        chk("oe", 16'({p1_pad_oe_o, p2_pad_oe_o}), 16'h0000);
        rd(4'hf);
        chk("unmapped", 16'(r), 16'h0000);
        $display("reset test end");
    endtask
    task automatic t_gpio();
        cfg(8'h0f, 8'h00, 8'h1f, 8'h00, 8'h00);
        wr(PFM_ADDR_P1_OUT, 8'h0a);
        wr(PFM_ADDR_P2_OUT, 8'h15);
        settle();
        chk("p1", 16'({p1_pad_oe_o, p1_pad_o}), 16'({4'hf, 4'ha}));
        chk("p2", 16'({p2_pad_oe_o, p2_pad_o}), 16'({5'h1f, 5'h15}));
        cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        ext_on <= 1'b1;
        p1_ext <= 4'h5;
        p2_ext <= 5'h0a;
        settle();
        rd(PFM_ADDR_P1_IN);
        chk("p1 in", 16'(r), 16'h0005);
        rd(PFM_ADDR_P2_IN);
        chk("p2 in", 16'(r), 16'h000a);
        chk("in oe", 16'({p1_pad_oe_o, p2_pad_oe_o}), 16'h0000);
        $display("gpio test end");
    endtask
    task automatic t_func();
        cfg(8'h0f, 8'h0f, 8'h1f, 8'h1f, 8'h00);
        periph_i <= '{1'b0, 1'b1, 3'b011};
        settle();
        chk("p1 fn", 16'({p1_pad_oe_o, p1_pad_o}), 16'({4'hf, 4'b0110}));
        chk("p2 fn", 16'({p2_pad_oe_o, p2_pad_o}), 16'({5'h1f, 5'b01101}));
        @(posedge clk_i);
        periph_i <= '{1'b1, 1'b0, 3'b100};
        settle();
        chk("p1 fn b", 16'(p1_pad_o), 16'h0009);
        chk("p2 fn b", 16'(p2_pad_o), 16'h0012);
        cfg(8'h0f, 8'h0f, 8'h11, 8'h1f, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_i);
            p2_ext <= (i == 0) ? 5'h0a : 5'h04;
            settle();
            chk("tmr", 16'(timer_in_o), 16'({p2_ext[1], p2_ext[2], p2_ext[3]}));
        end
        $display("function test end");
    endtask
    task automatic t_ana();
        cfg(8'h0f, 8'h0f, 8'h11, 8'h1f, 8'h1f);
        periph_i <= '{1'b1, 1'b1, 3'b111};
        p2_ext <= 5'h1f;
        settle();
        chk("ana", 16'({analog_channel_en_o, p2_pad_oe_o, p2_pad_o}), 16'h7c00);
        rd(PFM_ADDR_P2_IN);
        chk("ana in", 16'({r, 5'h00, timer_in_o}), 16'h0000);
        cfg(8'h0f, 8'h0f, 8'h00, 8'h1f, 8'h0a);
        settle();
        rd(PFM_ADDR_P2_IN);
        chk("ana part", 16'({analog_channel_en_o, r}), 16'({5'h0a, 8'h15}));
        chk("ana tmr", 16'(timer_in_o), 16'h0002);
        $display("analog test end");
    endtask
    task automatic t_jtag();
        cfg(8'h0f, 8'h00, 8'h00, 8'h00, 8'h00);
        jtag_mode_i <= 1'b1;
        jtag_drv_i <= '{1'b1, 1'b1};
        p1_ext <= 4'b0101;
        settle();
        chk("jtag", 16'({p1_pad_oe_o, p1_pad_o[3], jtag_in_o}), 16'({4'h8, 1'b1, 3'b101}));
        rd(PFM_ADDR_STAT);
        chk("stat", 16'(r), 16'h0001);
        @(posedge clk_i);
        jtag_mode_i <= 1'b0;
        settle();
        chk("jtag off", 16'({p1_pad_oe_o, jtag_in_o}), 16'({4'hf, 3'b000}));
        $display("jtag test end");
    endtask
    task automatic t_por();
        cfg(8'h0f, 8'h0f, 8'h1f, 8'h1f, 8'h03);
        power_on_rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        power_on_rst_i <= 1'b0;
        settle();
        t_rst();
        rd(PFM_ADDR_P1_OUT);
        chk("kept", 16'(r), 16'h000a);
        $display("power-on test end");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_rst();
        t_gpio();
        t_func();
        t_ana();
        t_jtag();
        t_por();
        conclude();
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        conclude();
    end
endmodule // tb

// [src/pfm_pkg.sv]
// Constants, types and state for the port pin function multiplexer
// Operation
// - Select 0: direction bit picks input or output
// - Both resets return every pin to I/O
// - Port 1 bit 4 drives subsystem clock
// - JTAG mode hands port 1 bits 4-7 over
// - Port 1 bits 5-7 drive timer outputs 0-2
// - Port 2 bit 0 drives auxiliary clock
// - Port 2 bit 1: inverted clock in or subsystem clock
// - Port 2 bit 2: capture 0 alt or output 0
// - Port 2 bit 3: capture 1 alt or output 1
// - Port 2 bit 4 drives timer output 2
// - Analog enable gives pin to converter channel
// - Analog enable disables driver and input buffer
package pfm_pkg;

    // =====================================================================
    // Register offsets and fields
    // =====================================================================
    localparam logic [3:0] PFM_ADDR_P1_DIR = 4'h0;
    localparam logic [3:0] PFM_ADDR_P1_SEL = 4'h1;
    localparam logic [3:0] PFM_ADDR_P2_DIR = 4'h2;
    localparam logic [3:0] PFM_ADDR_P2_SEL = 4'h3;
    localparam logic [3:0] PFM_ADDR_AE     = 4'h4;
    localparam logic [3:0] PFM_ADDR_P1_IN  = 4'h5;
    localparam logic [3:0] PFM_ADDR_P2_IN  = 4'h6;
    localparam logic [3:0] PFM_ADDR_P1_OUT = 4'h7;
    localparam logic [3:0] PFM_ADDR_P2_OUT = 4'h8;
    localparam logic [3:0] PFM_ADDR_STAT   = 4'h9;

    localparam int         PFM_P1_N     = 4;
    localparam int         PFM_P2_N     = 5;
    localparam logic [3:0] PFM_P1_RST   = 4'h0;
    localparam logic [4:0] PFM_P2_RST   = 5'h00;
    localparam logic [7:0] PFM_RD_ZERO  = 8'h00;
    localparam logic       PFM_IN_IDLE  = 1'b0;

    // =====================================================================
    // Carriers
    // =====================================================================
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfm_bus_req_t;

    typedef struct packed {
        logic       subsystem_clock_out;
        logic       aclk;
        logic [2:0] ta_out;
    } pfm_periph_t;

    typedef struct packed {
        logic       timer_a_inverted_clock_in;
        logic       timer_a_capture_in_0_alt;
        logic       timer_a_capture_in_1_alt;
    } pfm_timer_in_t;

    typedef struct packed {
        logic       tdo;
        logic       tdo_oe;
    } pfm_jtag_drv_t;

    typedef struct packed {
        logic       tck;
        logic       tms;
        logic       tdi;
    } pfm_jtag_in_t;

    typedef struct packed {
        logic [3:0] p1_dir;
        logic [3:0] p1_sel;
        logic [3:0] p1_out;
        logic [4:0] p2_dir;
        logic [4:0] p2_sel;
        logic [4:0] p2_out;
        logic [4:0] ae;
        logic [7:0] rdata;
    } pfm_cfg_t;

endpackage

// [src/pfm_sync.sv]
// Two flip-flop synchroniser for a bus of pad inputs
`timescale 1ns/1ns
module pfm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pfm_sync_st_t;

    pfm_sync_st_t st_q;
    pfm_sync_st_t st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule // pfm_sync

// [src/pfm_top.sv]
// Pin function multiplexer for port 1 bits 4-7 and port 2 bits 0-4
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ns
module pfm_top (
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   power_on_rst_i,
    input  wire pfm_pkg::pfm_bus_req_t  bus_i,
    output logic [7:0]                  rdata_o,
    input  wire logic                   jtag_mode_i,
    input  wire pfm_pkg::pfm_periph_t   periph_i,
    input  wire pfm_pkg::pfm_jtag_drv_t jtag_drv_i,
    output pfm_pkg::pfm_jtag_in_t       jtag_in_o,
    output pfm_pkg::pfm_timer_in_t      timer_in_o,
    input  wire logic [3:0]             p1_pad_i,
    output logic [3:0]                  p1_pad_o,
    output logic [3:0]                  p1_pad_oe_o,
    input  wire logic [4:0]             p2_pad_i,
    output logic [4:0]                  p2_pad_o,
    output logic [4:0]                  p2_pad_oe_o,
    output logic [4:0]                  analog_channel_en_o
);
    import pfm_pkg::*;

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        pfm_cfg_t       cfg;
        logic [3:0]     p1_in;
        logic [4:0]     p2_in;
        logic [3:0]     p1_o;
        logic [3:0]     p1_oe;
        logic [4:0]     p2_o;
        logic [4:0]     p2_oe;
        logic [4:0]     an;
        pfm_jtag_in_t   jin;
        pfm_timer_in_t  tin;
    } pfm_st_t;

    pfm_st_t    st_q;
    pfm_st_t    st_d;
    logic [3:0] p1_s;
    logic [4:0] p2_s;
    logic       jtag_s;
    logic       por_s;
    logic [4:0] p2_live;
    logic [3:0] p1_alt;
    logic [4:0] p2_alt;

    // =====================================================================
    // Pad and mode synchronisers
    // =====================================================================
    pfm_sync #(.W(11)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       ({power_on_rst_i, jtag_mode_i, p2_pad_i, p1_pad_i}),
        .q_o       ({por_s, jtag_s, p2_s, p1_s})
    );

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb
    begin
        st_d = st_q;

        // Register writes
        if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                PFM_ADDR_P1_DIR: st_d.cfg.p1_dir = bus_i.wdata[PFM_P1_N-1:0];
                PFM_ADDR_P1_SEL: st_d.cfg.p1_sel = bus_i.wdata[PFM_P1_N-1:0];
                PFM_ADDR_P2_DIR: st_d.cfg.p2_dir = bus_i.wdata[PFM_P2_N-1:0];
                PFM_ADDR_P2_SEL: st_d.cfg.p2_sel = bus_i.wdata[PFM_P2_N-1:0];
                PFM_ADDR_AE:     st_d.cfg.ae     = bus_i.wdata[PFM_P2_N-1:0];
                PFM_ADDR_P1_OUT: st_d.cfg.p1_out = bus_i.wdata[PFM_P1_N-1:0];
                PFM_ADDR_P2_OUT: st_d.cfg.p2_out = bus_i.wdata[PFM_P2_N-1:0];
                default:         st_d.cfg.p1_out = st_q.cfg.p1_out;
            endcase
        end

        // Register reads, data in the following cycle
        st_d.cfg.rdata = PFM_RD_ZERO;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                PFM_ADDR_P1_DIR: st_d.cfg.rdata = {4'h0, st_q.cfg.p1_dir};
                PFM_ADDR_P1_SEL: st_d.cfg.rdata = {4'h0, st_q.cfg.p1_sel};
                PFM_ADDR_P2_DIR: st_d.cfg.rdata = {3'h0, st_q.cfg.p2_dir};
                PFM_ADDR_P2_SEL: st_d.cfg.rdata = {3'h0, st_q.cfg.p2_sel};
                PFM_ADDR_AE:     st_d.cfg.rdata = {3'h0, st_q.cfg.ae};
                PFM_ADDR_P1_IN:  st_d.cfg.rdata = {4'h0, st_q.p1_in};
                PFM_ADDR_P2_IN:  st_d.cfg.rdata = {3'h0, st_q.p2_in};
                PFM_ADDR_P1_OUT: st_d.cfg.rdata = {4'h0, st_q.cfg.p1_out};
                PFM_ADDR_P2_OUT: st_d.cfg.rdata = {3'h0, st_q.cfg.p2_out};
                PFM_ADDR_STAT:   st_d.cfg.rdata = {7'h00, jtag_s};
                default:         st_d.cfg.rdata = PFM_RD_ZERO;
            endcase
        end

        // Port 1 bits 4-7: peripheral drive then JTAG takeover
        p1_alt = {periph_i.ta_out[2], periph_i.ta_out[1],
                  periph_i.ta_out[0], periph_i.subsystem_clock_out};
        for (int i = 0; i < PFM_P1_N; i++)
        begin
            st_d.p1_oe[i] = st_q.cfg.p1_dir[i];
            st_d.p1_o[i]  = st_q.cfg.p1_sel[i] ? p1_alt[i]
                                               : st_q.cfg.p1_out[i];
            st_d.p1_in[i] = p1_s[i];
        end
        if (jtag_s)
        begin
            // JTAG owns all four pins; only the data out pin may drive
            st_d.p1_oe = {jtag_drv_i.tdo_oe, 3'h0};
            st_d.p1_o  = {jtag_drv_i.tdo, 3'h0};
            st_d.p1_in = {PFM_P1_N{PFM_IN_IDLE}};
        end
        st_d.jin.tck = jtag_s ? p1_s[0] : PFM_IN_IDLE;
        st_d.jin.tms = jtag_s ? p1_s[1] : PFM_IN_IDLE;
        st_d.jin.tdi = jtag_s ? p1_s[2] : PFM_IN_IDLE;

        // Port 2 bits 0-4
        p2_alt = {periph_i.ta_out[2], periph_i.ta_out[1], periph_i.ta_out[0],
                  periph_i.subsystem_clock_out,
                  periph_i.aclk};
        for (int i = 0; i < PFM_P2_N; i++)
        begin
            p2_live[i] = st_q.cfg.ae[i] ? PFM_IN_IDLE : p2_s[i];
            st_d.p2_oe[i] = st_q.cfg.p2_dir[i] & ~st_q.cfg.ae[i];
            st_d.p2_o[i]  = st_q.cfg.ae[i] ? 1'b0
                          : (st_q.cfg.p2_sel[i] ? p2_alt[i]
                                                : st_q.cfg.p2_out[i]);
            st_d.p2_in[i] = p2_live[i];
            st_d.an[i]    = st_q.cfg.ae[i];
        end

        // Timer inputs only when selected as input function
        st_d.tin.timer_a_inverted_clock_in = (st_q.cfg.p2_sel[1] & ~st_q.cfg.p2_dir[1])
                                             ? p2_live[1] : PFM_IN_IDLE;
        st_d.tin.timer_a_capture_in_0_alt  = (st_q.cfg.p2_sel[2] & ~st_q.cfg.p2_dir[2])
                                             ? p2_live[2] : PFM_IN_IDLE;
        st_d.tin.timer_a_capture_in_1_alt  = (st_q.cfg.p2_sel[3] & ~st_q.cfg.p2_dir[3])
                                             ? p2_live[3] : PFM_IN_IDLE;

        // Either reset returns the pins to general I/O
        if (por_s)
        begin
            st_d.cfg.p1_dir = PFM_P1_RST;
            st_d.cfg.p1_sel = PFM_P1_RST;
            st_d.cfg.p2_dir = PFM_P2_RST;
            st_d.cfg.p2_sel = PFM_P2_RST;
            st_d.cfg.ae     = PFM_P2_RST;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign rdata_o             = st_q.cfg.rdata;
    assign p1_pad_o            = st_q.p1_o;
    assign p1_pad_oe_o         = st_q.p1_oe;
    assign p2_pad_o            = st_q.p2_o;
    assign p2_pad_oe_o         = st_q.p2_oe;
    assign analog_channel_en_o = st_q.an;
    assign jtag_in_o           = st_q.jin;
    assign timer_in_o          = st_q.tin;
endmodule // pfm_top
